//--- hdl/xcl_config_latches.sv
// Two-rank configuration latches of a 32x16 crosspoint with Avalon-MM access
//
// Overview of operation
// [RQ1] Each of 16 outputs selects exactly one of 32 inputs, or none when disabled.
// [RQ2] Selections are independent, so one input may feed several outputs.
// [RQ3] Settings land first in a first rank, loaded serially or by addressed write.
// [RQ4] An update copies the whole first rank into the second rank at once.
// [RQ5] The bit leaving the shift chain end is driven on the serial output.
// [RQ6] Reset clears the second rank and leaves the first rank untouched.
// [RQ7] A broadcast parallel write loads every first-rank slot at once.
// [RQ8] The host shifts a full image; single outputs cannot be set serially.
// [RQ9] One serial bit is taken per falling serial clock, 192 bits per device.
// [RQ10] The host sends output 15 enable first, source MSB first, then 96 zeros.
// [RQ11] A falling write strobe stores index and six data bits into one slot.
// [RQ12] While update is low the second rank follows the first rank.
// [RQ13] After reset all outputs stay off until the next update.
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
module xcl_config_latches (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic [7:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic                         serial_clock,
  input  wire logic                         serial_data_in,
  output logic                              serial_data_out,
  input  wire logic                         write_strobe_n,
  input  wire logic                         update_n,
  input  wire logic                         serial_parallel_select,
  input  wire logic [xcl_pkg::IDX_W-1:0]    output_index_lines,
  input  wire logic                         output_enable_bit,
  input  wire logic [xcl_pkg::SRC_W-1:0]    source_select_bits,
  output logic      [xcl_pkg::ROUTE_W-1:0]  route_select
);
  // Top bit of the shift chain
  localparam int HIGH = xcl_pkg::CHAIN_LEN - 1;

  // Pin sampling
  logic [xcl_pkg::SYNC_W-1:0] pin_lvl;
  xcl_pin_sync #(
    .W   (xcl_pkg::SYNC_W),
    .RST (xcl_pkg::SYNC_RST)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   ({serial_clock, serial_data_in, write_strobe_n, update_n,
             serial_parallel_select, output_index_lines,
             output_enable_bit, source_select_bits}),
    .level (pin_lvl)
  );

  wire                        sclk_lvl  = pin_lvl[xcl_pkg::PIN_SCLK];
  wire                        sdin_lvl  = pin_lvl[xcl_pkg::PIN_SDIN];
  wire                        wr_n_lvl  = pin_lvl[xcl_pkg::PIN_WR_N];
  wire                        upd_n_lvl = pin_lvl[xcl_pkg::PIN_UPD_N];
  wire                        par_mode  = pin_lvl[xcl_pkg::PIN_MODE];
  wire [xcl_pkg::IDX_W-1:0]   pin_idx   = pin_lvl[xcl_pkg::PIN_IDX +: xcl_pkg::IDX_W];
  wire [xcl_pkg::CFG_W-1:0]   pin_cfg   = pin_lvl[xcl_pkg::PIN_CFG +: xcl_pkg::CFG_W];

  // Previous levels for edge detection
  logic sclk_q_reg;
  logic wr_n_q_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q_reg <= 1'h1;
      wr_n_q_reg <= 1'h1;
    end else begin
      sclk_q_reg <= sclk_lvl;
      wr_n_q_reg <= wr_n_lvl;
    end
  end

  // Register bus handshake: one wait state per access
  logic                      wait_reg;
  logic [31:0]               rdata_reg;
  logic                      bcast_reg;
  logic [9:0]                wdata_reg;
  wire                       bus_req   = avs_read | avs_write;
  wire                       bus_take  = bus_req & wait_reg;
  wire                       bus_done  = bus_req & ~wait_reg;
  wire                       wr_done   = avs_write & bus_done;
  wire                       hit_ctrl  = avs_address == xcl_pkg::OFF_CTRL;
  wire                       hit_wdata = avs_address == xcl_pkg::OFF_WDATA;
  wire                       hit_stat  = avs_address == xcl_pkg::OFF_STATUS;
  wire [1:0]                 page      = avs_address[7:6];
  wire [xcl_pkg::IDX_W-1:0]  page_idx  = avs_address[5:2];
  wire                       page_lo   = avs_address[1:0] == 2'h0;
  wire                       hit_route = page_lo & (page == xcl_pkg::PAGE_ROUTE);
  wire                       hit_first = page_lo & (page == xcl_pkg::PAGE_FIRST);

  // Software strobes taken at the completing edge
  wire sw_upd = wr_done & hit_ctrl & avs_writedata[xcl_pkg::CTRL_UPD];
  wire sw_wr  = wr_done & hit_ctrl & avs_writedata[xcl_pkg::CTRL_WR];

  // Programming events
  wire ser_fall = sclk_q_reg & ~sclk_lvl;
  wire wr_fall  = wr_n_q_reg & ~wr_n_lvl;
  wire shift_en = ser_fall & ~par_mode & wr_n_lvl;                 // RQ9
  wire pin_wr   = wr_fall & par_mode;                              // RQ11
  wire par_load = pin_wr | sw_wr;                                  // RQ3
  wire [xcl_pkg::IDX_W-1:0] par_idx = pin_wr ? pin_idx :
                                      wdata_reg[xcl_pkg::WD_IDX +: xcl_pkg::IDX_W];
  wire [xcl_pkg::CFG_W-1:0] par_cfg = pin_wr ? pin_cfg :
                                      wdata_reg[xcl_pkg::IDX_W +: xcl_pkg::CFG_W];
  wire load = ~upd_n_lvl | sw_upd;                                 // RQ12

  // First rank: the shift chain itself, deliberately not reset
  logic [HIGH:0] chain_reg;
  logic [HIGH:0] chain_next;
  always_comb begin
    chain_next = chain_reg;
    if (shift_en) begin
      chain_next = {chain_reg[HIGH-1:0], sdin_lvl};                // RQ9
    end else if (par_load) begin
      for (int i = 0; i < xcl_pkg::NUM_OUT; i++) begin
        if (bcast_reg || par_idx == i[xcl_pkg::IDX_W-1:0]) begin   // RQ7
          chain_next[xcl_pkg::PAD_LEN + i*xcl_pkg::CFG_W +: xcl_pkg::CFG_W] = par_cfg; // RQ11
        end
      end
    end
  end

  // First rank survives reset
  always_ff @(posedge clk) begin
    chain_reg <= chain_next;                                       // RQ6
  end

  // Chain end drives the cascade output
  assign serial_data_out = chain_reg[HIGH];                        // RQ5

  // Second rank slots
  xcl_slot_if slot_if[xcl_pkg::NUM_OUT] ();
  logic [xcl_pkg::NUM_OUT*xcl_pkg::CFG_W-1:0] held_flat;
  wire  [xcl_pkg::NUM_OUT*xcl_pkg::CFG_W-1:0] first_flat = chain_reg[HIGH:xcl_pkg::PAD_LEN];

  for (genvar g = 0; g < xcl_pkg::NUM_OUT; g++) begin : g_slot
    assign slot_if[g].load = load;                                 // RQ4
    assign slot_if[g].cfg  = first_flat[g*xcl_pkg::CFG_W +: xcl_pkg::CFG_W];
    xcl_route_slot u_slot (
      .clk   (clk),
      .rst_n (rst_n),
      .s     (slot_if[g])
    );
    assign held_flat[g*xcl_pkg::CFG_W +: xcl_pkg::CFG_W] = slot_if[g].held;
    assign route_select[g*xcl_pkg::NUM_IN +: xcl_pkg::NUM_IN] = slot_if[g].sel; // RQ2

    // Decoded select matches the held setting
    property p_decode;
      @(posedge clk) disable iff (!rst_n)
      slot_if[g].sel == (slot_if[g].held[xcl_pkg::EN_BIT] ?
        (32'h0000_0001 << slot_if[g].held[xcl_pkg::SRC_W-1:0]) : 32'h0000_0000);
    endproperty
    a_decode: assert property (p_decode)                           // RQ1
      else $error("output select does not match its setting");
  end

  // Readback selection
  wire [xcl_pkg::CFG_W-1:0] route_rd = held_flat[page_idx*xcl_pkg::CFG_W +: xcl_pkg::CFG_W];
  wire [xcl_pkg::CFG_W-1:0] first_rd = first_flat[page_idx*xcl_pkg::CFG_W +: xcl_pkg::CFG_W];
  wire [31:0] rdata_next =
      hit_ctrl  ? {29'h0, bcast_reg, 2'h0} :
      hit_wdata ? {18'h0, wdata_reg[9:4], 4'h0, wdata_reg[3:0]} :
      hit_stat  ? {29'h0, serial_data_out, upd_n_lvl, par_mode} :
      hit_route ? {26'h0, route_rd} :
      hit_first ? {26'h0, first_rd} : 32'h0000_0000;

  // Bus slave state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg  <= 1'h1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg  <= ~bus_take;
      if (avs_read && bus_take) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Software control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bcast_reg <= xcl_pkg::BCAST_RST;
      wdata_reg <= xcl_pkg::WDATA_RST;
    end else if (wr_done && hit_ctrl) begin
      bcast_reg <= avs_writedata[xcl_pkg::CTRL_BCAST];
    end else if (wr_done && hit_wdata) begin
      wdata_reg <= {avs_writedata[xcl_pkg::WD_CFG +: xcl_pkg::CFG_W],
                    avs_writedata[xcl_pkg::WD_IDX +: xcl_pkg::IDX_W]};
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Parallel write slot index, delayed by one cycle
  logic [xcl_pkg::IDX_W-1:0] chk_idx_q;
  always_ff @(posedge clk) begin
    chk_idx_q <= par_idx;
  end
  wire [xcl_pkg::CFG_W-1:0] chk_first_q =
    first_flat[chk_idx_q*xcl_pkg::CFG_W +: xcl_pkg::CFG_W];

  // Equal settings give equal selects
  property p_multicast;
    load && first_flat[5:0] == first_flat[11:6] |=>
      route_select[31:0] == route_select[63:32];
  endproperty
  a_multicast: assert property (p_multicast)                       // RQ2
    else $error("shared source not routed to both outputs");

  // Parallel write lands in its slot
  property p_par_load;
    par_load && !shift_en |=> chk_first_q == $past(par_cfg);
  endproperty
  a_par_load: assert property (p_par_load)                         // RQ3
    else $error("parallel write did not reach first rank");

  // Update copies the whole first rank
  property p_update;
    load |=> held_flat == $past(first_flat);
  endproperty
  a_update: assert property (p_update)                             // RQ4
    else $error("update did not copy the first rank");

  // Chain end follows the shift
  property p_serial_out;
    shift_en |=> serial_data_out === $past(chain_reg[HIGH-1]);
  endproperty
  a_serial_out: assert property (p_serial_out)                     // RQ5
    else $error("chain end not shifted to serial output");

  // Outputs off when reset ends
  property p_reset_off;
    $rose(rst_n) |-> route_select == '0 && held_flat == '0;
  endproperty
  a_reset_off: assert property (p_reset_off)                       // RQ6
    else $error("outputs not disabled after reset");

  // Broadcast fills every slot
  property p_bcast;
    par_load && bcast_reg && !shift_en |=>
      first_flat == {xcl_pkg::NUM_OUT{$past(par_cfg)}};
  endproperty
  a_bcast: assert property (p_bcast)                               // RQ7
    else $error("broadcast did not fill every slot");

  // Chain moves up by one bit; low bits may be unloaded
  property p_shift_in;
    shift_en |=> chain_reg[0] == $past(sdin_lvl) &&
                 chain_reg[HIGH:1] === $past(chain_reg[HIGH-1:0]);
  endproperty
  a_shift_in: assert property (p_shift_in)                         // RQ9
    else $error("serial bit not captured into chain");

  // Second rank frozen without update
  property p_hold;
    !load |=> $stable(held_flat);
  endproperty
  a_hold: assert property (p_hold)                                 // RQ13
    else $error("second rank changed without update");

  // Low update keeps second rank following
  property p_transparent;
    !upd_n_lvl [*2] |-> held_flat == $past(first_flat);
  endproperty
  a_transparent: assert property (p_transparent)                   // RQ12
    else $error("second rank not following first rank");

  // Pin strobe stores pin index and data
  property p_pin_write;
    pin_wr && !bcast_reg |=>
      chk_idx_q == $past(pin_idx) && chk_first_q == $past(pin_cfg);
  endproperty
  a_pin_write: assert property (p_pin_write)                       // RQ11
    else $error("pin write did not store its slot");

  // Wait state raised again after the completing cycle
  property p_wait_one;
    bus_done |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)                         // RQ3
    else $error("waitrequest low for more than one cycle");

  // Unmapped reads return zero
  property p_rd_unmapped;
    avs_read && bus_take && !hit_ctrl && !hit_wdata && !hit_stat && !hit_route &&
      !hit_first |=> avs_readdata == 32'h0000_0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)                   // RQ3
    else $error("unmapped read returned data");

  // Read data holds between reads
  property p_rdata_hold;
    !(avs_read && bus_take) |=> $stable(avs_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)                     // RQ3
    else $error("read data changed without a read");

  c_shift:  cover property (shift_en ##1 shift_en);
  c_pin_wr: cover property (pin_wr ##[1:50] load);
  c_bcast:  cover property (par_load && bcast_reg);
  c_bus:    cover property (bus_take ##1 bus_done && avs_read);
  c_sw_wr:  cover property (sw_wr);
endmodule : xcl_config_latches

//--- hdl/xcl_pkg.sv
// Shared constants for the crosspoint configuration latches
package xcl_pkg;
  // Array geometry
  localparam int NUM_OUT   = 16;
  localparam int NUM_IN    = 32;
  localparam int SRC_W     = 5;
  localparam int CFG_W     = 6;
  localparam int IDX_W     = 4;
  localparam int EN_BIT    = 5;
  localparam int CHAIN_LEN = 192;
  localparam int PAD_LEN   = 96;
  localparam int ROUTE_W   = NUM_OUT * NUM_IN;
  // Pin synchroniser vector
  localparam int SYNC_W    = 15;
  localparam logic [SYNC_W-1:0] SYNC_RST = 15'h5800;
  localparam int PIN_SCLK  = 14;
  localparam int PIN_SDIN  = 13;
  localparam int PIN_WR_N  = 12;
  localparam int PIN_UPD_N = 11;
  localparam int PIN_MODE  = 10;
  localparam int PIN_IDX   = 6;
  localparam int PIN_CFG   = 0;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_WDATA  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [1:0] PAGE_ROUTE = 2'h1;
  localparam logic [1:0] PAGE_FIRST = 2'h2;
  // Field positions
  localparam int CTRL_UPD   = 0;
  localparam int CTRL_WR    = 1;
  localparam int CTRL_BCAST = 2;
  localparam int WD_IDX     = 0;
  localparam int WD_CFG     = 8;
  // Reset values
  localparam logic       BCAST_RST = 1'h0;
  localparam logic [9:0] WDATA_RST = 10'h000;
endpackage : xcl_pkg

//--- hdl/xcl_slot_if.sv
// Carrier between the latch bank and one output slot
`timescale 1ns/100ps
interface xcl_slot_if;
  logic                           load;
  logic [xcl_pkg::CFG_W-1:0]      cfg;
  logic [xcl_pkg::CFG_W-1:0]      held;
  logic [xcl_pkg::NUM_IN-1:0]     sel;
  modport bank (output load, output cfg, input held, input sel);
  modport slot (input load, input cfg, output held, output sel);
endinterface : xcl_slot_if

//--- hdl/xcl_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module xcl_pin_sync #(
  parameter int               W   = 1,
  parameter logic [W-1:0]     RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_reg;
  wire  [W-1:0] agree      = ~(s2_reg ^ s3_reg);
  wire  [W-1:0] level_next = (agree & s3_reg) | (~agree & level_reg);

  // Stages plus filtered level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg    <= RST;
      s2_reg    <= RST;
      s3_reg    <= RST;
      level_reg <= RST;
    end else begin
      s1_reg    <= pin;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
endmodule : xcl_pin_sync

//--- hdl/xcl_route_slot.sv
// Second-rank latch and source decoder for one output
`timescale 1ns/100ps
module xcl_route_slot (
  input  wire logic clk,
  input  wire logic rst_n,
  xcl_slot_if.slot  s
);
  logic [xcl_pkg::CFG_W-1:0]  held_reg;
  logic [xcl_pkg::NUM_IN-1:0] sel_reg;
  wire  [xcl_pkg::NUM_IN-1:0] sel_next = s.cfg[xcl_pkg::EN_BIT] ?  // RQ1
                                (32'h0000_0001 << s.cfg[xcl_pkg::SRC_W-1:0]) : 32'h0000_0000;

  // Reset disables the output; load copies first rank
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_reg <= '0;                                              // RQ6
      sel_reg  <= '0;
    end else if (s.load) begin                                     // RQ13
      held_reg <= s.cfg;
      sel_reg  <= sel_next;
    end
  end

  assign s.held = held_reg;
  assign s.sel  = sel_reg;
endmodule : xcl_route_slot

//--- bench/xcl_host_model.sv
// Host controller model driving the programming pins
`timescale 1ns/100ps
module xcl_host_model (
  input  wire logic                      clk,
  output logic                           serial_clock,
  output logic                           serial_data_in,
  output logic                           write_strobe_n,
  output logic                           update_n,
  output logic                           serial_parallel_select,
  output logic [xcl_pkg::IDX_W-1:0]      output_index_lines,
  output logic                           output_enable_bit,
  output logic [xcl_pkg::SRC_W-1:0]      source_select_bits
);
  // Idle pins: strobes and update high, serial clock parked high
  initial begin
    serial_clock = 1'h1;
    serial_data_in = 1'h0;
    write_strobe_n = 1'h1;
    update_n = 1'h1;
    serial_parallel_select = 1'h1;
    output_index_lines = 4'h0;
    output_enable_bit = 1'h0;
    source_select_bits = 5'h00;
  end
  // Each pin level is held well past the filter depth
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold
  // Data settles first, bit taken at the falling serial clock, then data inverted
  task automatic shift_bit(input logic b);
    serial_data_in <= b;
    hold(3);
    serial_clock <= 1'h0;
    hold(5);
    serial_clock <= 1'h1;
    serial_data_in <= ~b;
    hold(5);
  endtask : shift_bit
  // Full image, top bit first, update kept high throughout
  task automatic shift_image(input logic [xcl_pkg::CHAIN_LEN-1:0] img);
    serial_parallel_select <= 1'h0;
    write_strobe_n <= 1'h1;
    update_n <= 1'h1;
    hold(5);
    for (int i = xcl_pkg::CHAIN_LEN - 1; i >= 0; i--) begin
      shift_bit(img[i]);
    end
  endtask : shift_image
  // Addressed write on the falling write strobe
  task automatic par_write(input logic [3:0] idx, input logic en, input logic [4:0] src);
    serial_parallel_select <= 1'h1;
    output_index_lines <= idx;
    output_enable_bit <= en;
    source_select_bits <= src;
    hold(5);
    write_strobe_n <= 1'h0;
    hold(5);
    write_strobe_n <= 1'h1;
    hold(5);
  endtask : par_write
  // Short low pulse on update
  task automatic pulse_update();
    update_n <= 1'h0;
    hold(5);
    update_n <= 1'h1;
    hold(10);
  endtask : pulse_update
endmodule : xcl_host_model

//--- bench/tb_top.sv
// Testbench for the crosspoint configuration latches
`timescale 1ns/100ps
module tb_top;
  logic                          clk;
  logic                          rst_n;
  logic [7:0]                    avs_address;
  logic                          avs_read;
  logic                          avs_write;
  logic [31:0]                   avs_writedata;
  logic [31:0]                   avs_readdata;
  logic                          avs_waitrequest;
  logic                          serial_clock;
  logic                          serial_data_in;
  logic                          serial_data_out;
  logic                          write_strobe_n;
  logic                          update_n;
  logic                          serial_parallel_select;
  logic [xcl_pkg::IDX_W-1:0]     output_index_lines;
  logic                          output_enable_bit;
  logic [xcl_pkg::SRC_W-1:0]     source_select_bits;
  logic [xcl_pkg::ROUTE_W-1:0]   route_select;
  logic [31:0]                   q;
  logic [xcl_pkg::CHAIN_LEN-1:0] img;
  int                            bad_count;
  int                            n_checks;

  xcl_config_latches xcl_config_latches_i (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .write_strobe_n(write_strobe_n), .update_n(update_n),
    .serial_parallel_select(serial_parallel_select),
    .output_index_lines(output_index_lines), .output_enable_bit(output_enable_bit),
    .source_select_bits(source_select_bits), .route_select(route_select));

  xcl_host_model xcl_host_model_i (.clk(clk), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .write_strobe_n(write_strobe_n),
    .update_n(update_n), .serial_parallel_select(serial_parallel_select),
    .output_index_lines(output_index_lines), .output_enable_bit(output_enable_bit),
    .source_select_bits(source_select_bits));

  // Clock generation
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Comparison with report
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (exp !== got) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One output's one-hot select, zero when disabled
  task automatic chk_route(input int g, input logic en, input logic [4:0] src);
    check($sformatf("route_select[%0d]", g), en ? (32'h1 << src) : 32'h0,
          route_select[32*g +: 32]);
  endtask : chk_route

  // Avalon transfer held until waitrequest is sampled low
  task automatic av_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk);
    if (n >= 50) begin
      bad_count++;
      $display("Error avs_waitrequest expected 0 seen timeout");
      finish_test();
    end
  endtask : av_xfer

  task automatic do_reset();
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (10) @(posedge clk);
  endtask : do_reset

  task automatic t_reset();
    for (int g = 0; g < 16; g++) chk_route(g, 1'h0, 5'h00);
    av_xfer(1'h0, 8'h08, 32'h0);
    check("status", 32'h3, q & 32'h3);
    $display("test reset done");
  endtask : t_reset

  task automatic t_parallel();
    av_xfer(1'h1, 8'h00, 32'h4);
    xcl_host_model_i.par_write(4'h0, 1'h0, 5'h00);
    av_xfer(1'h1, 8'h00, 32'h0);
    av_xfer(1'h0, 8'hA4, 32'h0);
    check("first reg 9", 32'h0, q);
    xcl_host_model_i.par_write(4'h3, 1'h1, 5'h07);
    xcl_host_model_i.par_write(4'h5, 1'h1, 5'h07);
    xcl_host_model_i.par_write(4'h0, 1'h0, 5'h07);
    chk_route(3, 1'h0, 5'h00);
    xcl_host_model_i.pulse_update();
    chk_route(3, 1'h1, 5'h07);
    chk_route(5, 1'h1, 5'h07);
    chk_route(0, 1'h0, 5'h00);
    av_xfer(1'h0, 8'h4C, 32'h0);
    check("route reg 3", 32'h27, q);
    $display("test parallel done");
  endtask : t_parallel

  task automatic t_rst_keep();
    do_reset();
    chk_route(3, 1'h0, 5'h00);
    av_xfer(1'h0, 8'h8C, 32'h0);
    check("first reg 3", 32'h27, q);
    xcl_host_model_i.pulse_update();
    chk_route(3, 1'h1, 5'h07);
    $display("test reset keep done");
  endtask : t_rst_keep

  task automatic t_bcast();
    av_xfer(1'h1, 8'h00, 32'h4);
    xcl_host_model_i.par_write(4'h0, 1'h1, 5'h09);
    av_xfer(1'h1, 8'h00, 32'h0);
    av_xfer(1'h1, 8'h00, 32'h1);
    repeat (10) @(posedge clk);
    for (int g = 0; g < 16; g++) chk_route(g, 1'h1, 5'h09);
    av_xfer(1'h0, 8'h0C, 32'h0);
    check("unmapped read", 32'h0, q);
    $display("test broadcast done");
  endtask : t_bcast

  task automatic t_sw_write();
    av_xfer(1'h1, 8'h04, 32'h3506);
    av_xfer(1'h0, 8'h04, 32'h0);
    check("wdata reg", 32'h3506, q);
    av_xfer(1'h1, 8'h00, 32'h2);
    av_xfer(1'h0, 8'h98, 32'h0);
    check("first reg 6", 32'h35, q);
    chk_route(6, 1'h1, 5'h09);
    av_xfer(1'h1, 8'h00, 32'h1);
    chk_route(6, 1'h1, 5'h15);
    chk_route(7, 1'h1, 5'h09);
    $display("test software write done");
  endtask : t_sw_write

  task automatic t_serial();
    img = '0;
    for (int g = 0; g < 16; g++) img[96 + 6*g +: 6] = {g[0], 5'(g + 16)};
    xcl_host_model_i.shift_image(img);
    repeat (10) @(posedge clk);
    check("serial_data_out", {31'h0, img[191]}, {31'h0, serial_data_out});
    chk_route(2, 1'h1, 5'h09);
    xcl_host_model_i.pulse_update();
    for (int g = 0; g < 16; g++) chk_route(g, g[0], 5'(g + 16));
    $display("test serial done");
  endtask : t_serial

  // Main sequence
  initial begin
    bad_count = 0;
    n_checks = 0;
    rst_n = 1'h0;
    avs_address = 8'h00;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (10) @(posedge clk);
    t_reset();
    t_parallel();
    t_rst_keep();
    t_bcast();
    t_sw_write();
    t_serial();
    finish_test();
  end
endmodule : tb_top
